// [src/cbt_pkg.sv]
// Shared constants and types for the CAN bit timing and mailbox block
package cbt_pkg;
  // ----------------------------------------
  // Register offsets
  // ----------------------------------------
  localparam logic [7:0] ADDR_TIMING = 8'h00;
  localparam logic [7:0] ADDR_DIR = 8'h04;
  localparam logic [7:0] ADDR_TXREQ = 8'h08;
  localparam logic [7:0] ADDR_STATUS = 8'h0C;
  // ----------------------------------------
  // Field positions and reset values
  // ----------------------------------------
  localparam int RSV_BIT = 8;
  localparam int MAP_HI_LSB = 9;
  localparam logic [15:0] TIMING_RST = 16'h0000;
  localparam logic [15:0] DIR_RST = 16'h0100;
  localparam logic [15:0] TXREQ_RST = 16'h0000;
  localparam logic [1:0] STAT_W = 2'h2;
  // Fixed quanta of a bit beyond the two programmed codes
  localparam int FIXED_QUANTA = 3;
  localparam logic [4:0] SYNC_QUANTA = 5'h01;
  // ----------------------------------------
  // Types
  // ----------------------------------------
  typedef struct packed {
    logic [1:0] resync_jump_width;
    logic [5:0] rate_prescaler;
    logic sample_point_mode;
    logic [2:0] second_time_segment;
    logic [3:0] first_time_segment;
  } cbt_timing_s;
  typedef enum logic [2:0] {
    PH_SYNC = 3'b001,
    PH_SEG1 = 3'b010,
    PH_SEG2 = 3'b100
  } cbt_phase_e;
endpackage

// [src/cbt_core.sv]
// CAN bit timing engine with mailbox direction and transmit request
//
// Design decisions made here: the APB interface to the registers and the register addresses.
`timescale 1ns/1ps
`default_nettype none
// Functional notes
// RULE1: Software keeps 3 plus both segment codes within 8 to 25 quanta.
// RULE2: Zero prescaler needs second segment code above 001, else above 000.
// RULE3: Software uses only permitted first/second segment code pairs.
// RULE4: Mode 0 samples once at first segment end; mode 1 three times.
// RULE5: Second segment field bits 6..4 lasts code plus one quanta.
// RULE6: First segment field bits 3..0 lasts code plus one quanta.
// RULE7: Direction bit 0 transmit, 1 receive; all reset to transmit.
// RULE8: Register bits 15..9 are mailboxes 7..1, bits 7..0 mailboxes 15..8.
// RULE9: Direction reserved bit 8 reads 1; software writes 1.
// RULE10: Software loads the message before setting its transmit request.
// RULE11: A set transmit request holds the mailbox waiting for arbitration; tx_wait is raised only for transmit mailboxes (direction bit 0).
// RULE12: Hardware clears a request on transmit or cancel completion.
// RULE13: Transmit request reserved bit 8 reads 0; software writes 0.
// RULE14: Quantum is twice prescaler plus one clocks; bit is 3+codes quanta.
// RULE15: Each resync adjusts at most jump width code plus one quanta.
// RULE16: Software keeps first segment over second, second over jump width.
// RULE17: Mailbox 0 has no bits; writing 0 to a request does nothing.
module cbt_core #(
  parameter int MB_COUNT = 16
) (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire logic can_rx,
  input wire logic [15:0] tx_done,
  input wire logic [15:0] cancel_done,
  output logic [15:0] tx_wait,
  output logic bit_value,
  output logic sample_strobe
);
  if (MB_COUNT != 16) begin : g_bad_count
    $error("cbt_core serves exactly 16 mailboxes");
  end

  default clocking @(posedge pclk);
  endclocking
  default disable iff (!presetn);

  // ----------------------------------------
  // Mailbox to register bit mapping
  // ----------------------------------------
  function automatic logic [15:0] mb_to_reg(logic [15:0] mb, logic rsv);
    return {mb[7:1], rsv, mb[15:8]};
  endfunction

  function automatic logic [15:0] reg_to_mb(logic [15:0] r);
    return {r[7:0], r[15:9], 1'b0};
  endfunction

  // ----------------------------------------
  // Registers and APB slave
  // ----------------------------------------
  cbt_pkg::cbt_timing_s timing;
  logic [15:0] dir;
  logic [15:0] tx_req;
  cbt_pkg::cbt_phase_e phase;
  logic acc;
  logic wr;
  logic [15:0] tx_set;
  logic [15:0] wmb;

  // Pready rises one cycle into the access phase
  assign acc = psel && penable && pready;
  assign wr = acc && pwrite;
  assign wmb = reg_to_mb(pwdata[15:0]);
  assign tx_set = (wr && paddr == cbt_pkg::ADDR_TXREQ) ? wmb : 16'h0000;

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pready <= 1'b0;
    end else begin
      pready <= psel && penable && !pready;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      prdata <= 32'h0000_0000;
      pslverr <= 1'b0;
    end else if (psel && penable && !pready) begin
      pslverr <= 1'b0;
      case (paddr)
        cbt_pkg::ADDR_TIMING: prdata <= {16'h0000, timing};
        cbt_pkg::ADDR_DIR: prdata <= {16'h0000, mb_to_reg(dir, 1'b1)}; // RULE9
        cbt_pkg::ADDR_TXREQ:
          prdata <= {16'h0000, mb_to_reg(tx_req, 1'b0)}; // RULE13
        cbt_pkg::ADDR_STATUS: prdata <= {28'h0000000, phase, bit_value};
        default: begin
          prdata <= 32'h0000_0000;
          pslverr <= 1'b1;
        end
      endcase
    end else begin
      prdata <= 32'h0000_0000;
      pslverr <= 1'b0;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      timing <= cbt_pkg::TIMING_RST;
    end else if (wr && paddr == cbt_pkg::ADDR_TIMING) begin
      timing <= pwdata[15:0];
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      dir <= reg_to_mb(cbt_pkg::DIR_RST); // RULE7
    end else if (wr && paddr == cbt_pkg::ADDR_DIR) begin
      dir <= wmb; // RULE8 RULE17
    end
  end

  // A fresh software request wins over a completion in the same cycle
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      tx_req <= reg_to_mb(cbt_pkg::TXREQ_RST);
    end else begin
      tx_req <= (tx_req & ~(tx_done | cancel_done)) | tx_set; // RULE12 RULE17
    end
  end

  // Only transmit mailboxes contend for arbitration
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      tx_wait <= 16'h0000;
    end else begin
      tx_wait <= tx_req & ~dir; // RULE11
    end
  end

  // ----------------------------------------
  // Time quantum prescaler
  // ----------------------------------------
  logic [6:0] pre_cnt;
  logic [6:0] pre_lim;
  logic tick;
  logic restart;

  assign pre_lim = {timing.rate_prescaler, 1'b1};
  assign tick = pre_cnt == pre_lim;
  // New timings start a fresh bit, so a shorter segment never strands a count
  assign restart = wr && paddr == cbt_pkg::ADDR_TIMING;

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pre_cnt <= 7'h00;
    end else if (tick || pre_cnt > pre_lim || restart) begin
      pre_cnt <= 7'h00; // RULE14
    end else begin
      pre_cnt <= pre_cnt + 7'h01;
    end
  end

  // ----------------------------------------
  // Bit segments and resynchronisation
  // ----------------------------------------
  logic [4:0] q_cnt;
  logic [2:0] ext;
  logic [2:0] cut;
  logic [2:0] sjw_q;
  logic [4:0] seg1_len;
  logic [4:0] seg2_len;
  logic rx_last;
  logic edge_fall;
  logic resynced;
  logic seg1_end;
  logic seg2_end;

  assign sjw_q = {1'b0, timing.resync_jump_width} + 3'h1;
  assign seg1_len = {1'b0, timing.first_time_segment} + 5'h01 + {2'h0, ext};
  assign seg2_len = {2'h0, timing.second_time_segment} + 5'h01;
  assign edge_fall = rx_last && !can_rx;
  assign seg1_end = tick && phase == cbt_pkg::PH_SEG1
    && q_cnt == seg1_len - 5'h01; // RULE6
  assign seg2_end = tick && phase == cbt_pkg::PH_SEG2
    && q_cnt + {2'h0, cut} >= seg2_len - 5'h01; // RULE5

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      rx_last <= 1'b1;
    end else begin
      rx_last <= can_rx;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      phase <= cbt_pkg::PH_SYNC;
      q_cnt <= 5'h00;
    end else if (restart) begin
      phase <= cbt_pkg::PH_SYNC;
      q_cnt <= 5'h00;
    end else begin
      case (phase)
        cbt_pkg::PH_SYNC: begin
          if (tick && q_cnt == cbt_pkg::SYNC_QUANTA - 5'h01) begin
            phase <= cbt_pkg::PH_SEG1;
            q_cnt <= 5'h00;
          end
        end
        cbt_pkg::PH_SEG1: begin
          if (seg1_end) begin
            phase <= cbt_pkg::PH_SEG2;
            q_cnt <= 5'h00;
          end else if (tick) begin
            q_cnt <= q_cnt + 5'h01;
          end
        end
        cbt_pkg::PH_SEG2: begin
          if (seg2_end) begin
            phase <= cbt_pkg::PH_SYNC;
            q_cnt <= 5'h00;
          end else if (tick) begin
            q_cnt <= q_cnt + 5'h01;
          end
        end
        default: begin
          phase <= cbt_pkg::PH_SYNC;
          q_cnt <= 5'h00;
        end
      endcase
    end
  end

  // One adjustment per bit; a late edge stretches, an early one shortens
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ext <= 3'h0;
      cut <= 3'h0;
      resynced <= 1'b0;
    end else if (seg2_end || restart) begin
      ext <= 3'h0;
      cut <= 3'h0;
      resynced <= 1'b0;
    end else if (edge_fall && !resynced) begin
      resynced <= 1'b1;
      if (phase == cbt_pkg::PH_SEG1) begin
        ext <= (q_cnt[2:0] + 3'h1 > sjw_q || q_cnt > 5'h03) ? sjw_q
          : q_cnt[2:0] + 3'h1; // RULE15
      end else if (phase == cbt_pkg::PH_SEG2) begin
        cut <= sjw_q; // RULE15
      end
    end
  end

  // ----------------------------------------
  // Sampling
  // ----------------------------------------
  logic smp_early;
  logic smp_mid;

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      smp_early <= 1'b1;
      smp_mid <= 1'b1;
      bit_value <= 1'b1;
      sample_strobe <= 1'b0;
    end else begin
      sample_strobe <= 1'b0;
      if (tick && phase == cbt_pkg::PH_SEG1
          && q_cnt == seg1_len - 5'h02) begin
        smp_early <= can_rx;
      end
      if (seg1_end) begin
        smp_mid <= can_rx;
        if (!timing.sample_point_mode) begin
          bit_value <= can_rx; // RULE4
          sample_strobe <= 1'b1;
        end
      end
      // Third sample one quantum after the nominal point, then vote
      if (tick && phase == cbt_pkg::PH_SEG2 && q_cnt == 5'h00
          && timing.sample_point_mode) begin
        bit_value <= (smp_early & smp_mid) | (smp_early & can_rx)
          | (smp_mid & can_rx); // RULE4
        sample_strobe <= 1'b1;
      end
    end
  end

  // ----------------------------------------
  // Assertions
  // ----------------------------------------
  a_dir_rsv_one: assert property ( // RULE9
    pready && !pwrite && paddr == cbt_pkg::ADDR_DIR |-> prdata[8])
    else $error("direction reserved bit not 1");
  a_txreq_rsv_zero: assert property ( // RULE13
    pready && !pwrite && paddr == cbt_pkg::ADDR_TXREQ |-> !prdata[8])
    else $error("request reserved bit not 0");
  a_mb0_absent: assert property ( // RULE17
    !tx_req[0] && !dir[0])
    else $error("mailbox 0 has a bit");
  a_req_cleared: assert property ( // RULE12
    ##1 ((($past(tx_done) | $past(cancel_done)) & ~$past(tx_set)) & tx_req)
    == 16'h0000)
    else $error("request not cleared on completion");
  a_wait_follows: assert property ( // RULE11
    ##1 tx_wait == ($past(tx_req) & ~$past(dir)))
    else $error("wait output mismatch");
  a_dir_mapping: assert property ( // RULE8
    wr && paddr == cbt_pkg::ADDR_DIR |=> dir[7:1] == $past(pwdata[15:9])
    && dir[15:8] == $past(pwdata[7:0]))
    else $error("direction bit mapping wrong");
  a_seg2_bound: assert property ( // RULE5
    phase == cbt_pkg::PH_SEG2 |-> q_cnt <= {2'h0, timing.second_time_segment})
    else $error("second segment overrun");
  a_jump_limit: assert property ( // RULE15
    ext <= sjw_q && cut <= sjw_q)
    else $error("resync beyond jump width");
  a_prescale_bound: assert property ( // RULE14
    tick |=> pre_cnt == 7'h00)
    else $error("prescaler did not wrap");
  c_triple_sample: cover property (
    sample_strobe && timing.sample_point_mode);
  c_req_done: cover property (
    (tx_req & tx_done) != 16'h0000);
  c_resync: cover property (
    ext != 3'h0);
endmodule
`default_nettype wire

// [dv/cbt_bus_node.sv]
// Far side CAN node model: bus level and per-mailbox completions
`timescale 1ns/1ps
`default_nettype none
module cbt_bus_node (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic dominant,
  input wire logic [15:0] tx_wait,
  input wire logic [15:0] finish_tx,
  input wire logic [15:0] finish_cancel,
  output logic can_rx,
  output logic [15:0] tx_done,
  output logic [15:0] cancel_done
);
  // ----------------------------------------
  // Bus level and completion pulses
  // ----------------------------------------
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      can_rx <= 1'b1;
      tx_done <= 16'h0000;
      cancel_done <= 16'h0000;
    end else begin
      can_rx <= ~dominant;
      // Only a mailbox really waiting can win arbitration and finish
      tx_done <= finish_tx & tx_wait;
      cancel_done <= finish_cancel;
    end
  end
endmodule
`default_nettype wire

// [dv/tb_can_bit_timing_mailbox_setup.sv]
// Register and bit timing tests of the CAN timing and mailbox block
`timescale 1ns/1ps
`default_nettype none
module tb_can_bit_timing_mailbox_setup;
  logic pclk = 1'b0;
  logic presetn = 1'b0;
  logic psel = 1'b0;
  logic penable = 1'b0;
  logic pwrite = 1'b0;
  logic [7:0] paddr = 8'h00;
  logic [31:0] pwdata = 32'h0;
  logic [31:0] prdata;
  logic pready, pslverr, can_rx, bit_value, sample_strobe;
  logic [15:0] tx_done, cancel_done, tx_wait;
  logic dominant = 1'b0;
  logic [15:0] finish_tx = 16'h0000;
  logic [15:0] finish_cancel = 16'h0000;
  logic [31:0] rd;
  logic er;
  int err_total = 0;
  int compares = 0;
  always #2.5 pclk = ~pclk;
  cbt_core #(.MB_COUNT(16)) uut (.pclk(pclk), .presetn(presetn),
    .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
    .pwdata(pwdata), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .can_rx(can_rx), .tx_done(tx_done),
    .cancel_done(cancel_done), .tx_wait(tx_wait),
    .bit_value(bit_value), .sample_strobe(sample_strobe));
  cbt_bus_node node (.pclk(pclk), .presetn(presetn),
    .dominant(dominant), .tx_wait(tx_wait), .finish_tx(finish_tx),
    .finish_cancel(finish_cancel), .can_rx(can_rx), .tx_done(tx_done),
    .cancel_done(cancel_done));
  // ----------------------------------------
  // Helpers
  // ----------------------------------------
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    compares++;
    if (got !== exp) begin
      err_total++;
      $display("unexpected at %0t got %h exp %h", $time, got, exp);
    end
  endtask
  // Pready is sampled before the edge's own updates land
  task automatic apb(input logic w, input logic [7:0] a,
                     input logic [31:0] d);
    @(posedge pclk);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    do begin
      @(posedge pclk);
    end while (pready !== 1'b1);
    rd = prdata;
    er = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask
  task automatic rchk(input logic [7:0] a, input logic [31:0] exp);
    apb(1'b0, a, 32'h0);
    chk(rd, exp);
  endtask
  task automatic strobe(output int n);
    n = 0;
    do begin
      @(posedge pclk);
      n++;
    end while (sample_strobe !== 1'b1 && n < 300);
  endtask
  // Third gap is taken so a config change mid-bit has settled
  task automatic gap(input int exp);
    int n;
    strobe(n);
    strobe(n);
    strobe(n);
    chk(32'(n), 32'(exp));
  endtask
  task automatic done_t(input string s);
    $display("test %s done", s);
  endtask
  task automatic results;
    $display("compares %0d err_total %0d", compares, err_total);
    if (err_total == 0 && compares > 0)
      $display("ALL CHECKS OK");
    else
      $display("CHECKS NOT OK");
    $finish;
  endtask
  // ----------------------------------------
  // Tests
  // ----------------------------------------
  initial begin
    #200000;
    err_total++;
    results();
  end
  initial begin
    repeat (3) @(posedge pclk);
    presetn <= 1'b1;
    rchk(cbt_pkg::ADDR_TIMING, 32'h0000);
    rchk(cbt_pkg::ADDR_DIR, 32'h0100);
    rchk(cbt_pkg::ADDR_TXREQ, 32'h0000);
    chk(32'(tx_wait), 32'h0);
    done_t("reset");
    apb(1'b1, 8'h10, 32'h1234);
    chk(32'(er), 32'h1);
    rchk(8'h10, 32'h0);
    chk(32'(er), 32'h1);
    done_t("unmapped");
    apb(1'b1, cbt_pkg::ADDR_DIR, 32'hFEFF);
    rchk(cbt_pkg::ADDR_DIR, 32'hFFFF);
    apb(1'b1, cbt_pkg::ADDR_DIR, 32'h0101);
    rchk(cbt_pkg::ADDR_DIR, 32'h0101);
    done_t("direction");
    // Messages count as loaded before any request is set
    apb(1'b1, cbt_pkg::ADDR_TXREQ, 32'h8101);
    rchk(cbt_pkg::ADDR_TXREQ, 32'h8001);
    repeat (2) @(posedge pclk);
    chk(32'(tx_wait), 32'h0080);
    apb(1'b1, cbt_pkg::ADDR_TXREQ, 32'h0000);
    rchk(cbt_pkg::ADDR_TXREQ, 32'h8001);
    finish_tx <= 16'h0080;
    @(posedge pclk);
    finish_tx <= 16'h0000;
    repeat (3) @(posedge pclk);
    rchk(cbt_pkg::ADDR_TXREQ, 32'h0001);
    chk(32'(tx_wait), 32'h0);
    finish_cancel <= 16'h0100;
    @(posedge pclk);
    finish_cancel <= 16'h0000;
    repeat (3) @(posedge pclk);
    rchk(cbt_pkg::ADDR_TXREQ, 32'h0000);
    done_t("request");
    // Zero prescaler, seg1 5q, seg2 3q: 9 quanta of 2 clocks
    apb(1'b1, cbt_pkg::ADDR_TIMING, 32'h0024);
    rchk(cbt_pkg::ADDR_TIMING, 32'h0024);
    gap(18);
    dominant <= 1'b1;
    gap(18);
    chk(32'(bit_value), 32'h0);
    // Prescaler 1, sampling at three points, seg1 5q, seg2 2q: 32 clocks
    apb(1'b1, cbt_pkg::ADDR_TIMING, 32'h0194);
    gap(32);
    chk(32'(bit_value), 32'h0);
    dominant <= 1'b0;
    gap(32);
    chk(32'(bit_value), 32'h1);
    apb(1'b0, cbt_pkg::ADDR_STATUS, 32'h0);
    chk(32'(rd[0]), 32'h1);
    chk(32'($onehot(rd[3:1])) | {rd[31:4], 4'h0}, 32'h1);
    done_t("timing");
    results();
  end
endmodule
`default_nettype wire
